//--- prox_word_port_map.vh
// constants for the proximity sensor word port
`ifndef PROX_WORD_PORT_MAP_VH
`define PROX_WORD_PORT_MAP_VH
`define TARGET_ADDR 7'h41
`define CMD_CONF12 8'h03
`define CMD_CONF34 8'h04
`define CMD_CANCEL 8'h05
`define CMD_THRESH_LO 8'h06
`define CMD_THRESH_HI 8'h07
`define CMD_RESULT1 8'h08
`define CMD_RESULT2 8'h09
`define CMD_RESULT3 8'h0a
`define CMD_INT_FLAG 8'h0d
`define CMD_IDENT 8'h0e
`define CONF12_RESET 16'h0001
`define IDENT_VALUE 16'h4155
`define BIT_SHUTDOWN 0
`define BIT_INT_EN 1
`define BIT_HIRES 11
`define FLAG_AWAY 8
`define FLAG_CLOSE 9
`define FULL_12BIT 16'h0fff
`define FULL_16BIT 16'hffff
`endif

//--- prox_word_port.v
// i2c target port of the proximity sensor with word register access
`timescale 1ns/100ps
`include "prox_word_port_map.vh"

module prox_word_port (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_scl,
  input wire i_sda,
  input wire i_meas_valid,
  input wire [15:0] i_meas_count,
  output reg o_sda_out,
  output reg o_sda_oe,
  output reg o_int_n,
  output reg [15:0] o_conf12,
  output reg [15:0] o_conf34,
  output reg [15:0] o_cancel
);

  // ==========================================================
  // state codes
  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_CMD = 3'd2;
  localparam ST_WDATA = 3'd3;
  localparam ST_RDATA = 3'd4;
  localparam ST_ACK = 3'd5;
  localparam ST_HACK = 3'd6;
  localparam ST_SKIP = 3'd7;

  // clamp a raw count to the selected resolution
  function [15:0] clamp_count;
    input [15:0] raw;
    input hires;
    begin
      if (!hires && raw > `FULL_12BIT)
        clamp_count = `FULL_12BIT;
      else
        clamp_count = raw;
    end
  endfunction

  // ==========================================================
  // pin synchronisers
  reg [1:0] scl_sync_reg;
  reg [1:0] sda_sync_reg;
  reg scl_prev_reg;
  reg sda_prev_reg;
  wire scl_s = scl_sync_reg[1];
  wire sda_s = sda_sync_reg[1];
  wire scl_rise = scl_s && !scl_prev_reg;
  wire scl_fall = !scl_s && scl_prev_reg;
  wire start_cond = scl_s && scl_prev_reg && sda_prev_reg && !sda_s;
  wire stop_cond = scl_s && scl_prev_reg && !sda_prev_reg && sda_s;

  // two flip-flops on each pin, then an edge history
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], i_scl};
      sda_sync_reg <= {sda_sync_reg[0], i_sda};
      scl_prev_reg <= scl_s;
      sda_prev_reg <= sda_s;
    end
  end

  // ==========================================================
  // transaction engine and register file
  reg [2:0] state_reg;
  reg [2:0] after_ack_reg;
  reg [3:0] bit_cnt_reg;
  reg [7:0] shift_reg;
  reg [7:0] cmd_reg;
  reg [7:0] low_byte_reg;
  reg byte_idx_reg;
  reg [15:0] rd_word_reg;
  reg [15:0] thresh_lo_reg;
  reg [15:0] thresh_hi_reg;
  reg [15:0] result_reg;
  reg [15:0] flags_reg;
  reg flag_clear_reg;

  // register read mux
  reg [15:0] rd_mux;
  always @* begin
    case (cmd_reg)
      8'h00: rd_mux = 16'h0101;
      `CMD_CONF12: rd_mux = o_conf12;
      `CMD_CONF34: rd_mux = o_conf34;
      `CMD_CANCEL: rd_mux = o_cancel;
      `CMD_THRESH_LO: rd_mux = thresh_lo_reg;
      `CMD_THRESH_HI: rd_mux = thresh_hi_reg;
      `CMD_RESULT1, `CMD_RESULT2, `CMD_RESULT3: rd_mux = result_reg;
      `CMD_INT_FLAG: rd_mux = flags_reg;
      `CMD_IDENT: rd_mux = `IDENT_VALUE;
      default: rd_mux = 16'h0000;
    endcase
  end

  wire int_en = o_conf12[`BIT_INT_EN];
  wire meas_take = i_meas_valid && !o_conf12[`BIT_SHUTDOWN];
  wire [15:0] meas_clamped = clamp_count(i_meas_count, o_conf12[`BIT_HIRES]);
  wire set_close = meas_take && int_en && meas_clamped > thresh_hi_reg;
  wire set_away = meas_take && int_en && meas_clamped < thresh_lo_reg;

  // measurement capture and flags; a set wins over a read clear
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      result_reg <= 16'h0000;
      flags_reg <= 16'h0000;
      o_int_n <= 1'b1;
    end else begin
      if (meas_take)
        result_reg <= meas_clamped;
      flags_reg[`FLAG_CLOSE] <= set_close || (flags_reg[`FLAG_CLOSE] && !flag_clear_reg);
      flags_reg[`FLAG_AWAY] <= set_away || (flags_reg[`FLAG_AWAY] && !flag_clear_reg);
      o_int_n <= !(set_close || set_away || ((flags_reg[`FLAG_CLOSE] || flags_reg[`FLAG_AWAY]) && !flag_clear_reg));
    end
  end

  // byte level protocol on the synchronised bus
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_reg <= ST_IDLE;
      after_ack_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      cmd_reg <= 8'h00;
      low_byte_reg <= 8'h00;
      byte_idx_reg <= 1'b0;
      rd_word_reg <= 16'h0000;
      thresh_lo_reg <= 16'h0000;
      thresh_hi_reg <= 16'h0000;
      o_conf12 <= `CONF12_RESET;
      o_conf34 <= 16'h0000;
      o_cancel <= 16'h0000;
      o_sda_out <= 1'b0;
      o_sda_oe <= 1'b0;
      flag_clear_reg <= 1'b0;
    end else begin
      flag_clear_reg <= 1'b0;
      if (start_cond) begin
        state_reg <= ST_ADDR;
        bit_cnt_reg <= 4'h0;
        o_sda_oe <= 1'b0;
      end else if (stop_cond) begin
        state_reg <= ST_IDLE;
        o_sda_oe <= 1'b0;
      end else begin
        case (state_reg)
          ST_IDLE: o_sda_oe <= 1'b0;
          ST_ADDR, ST_CMD, ST_WDATA: begin
            if (scl_rise) begin
              shift_reg <= {shift_reg[6:0], sda_s};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
            if (scl_fall && bit_cnt_reg == 4'h8) begin
              bit_cnt_reg <= 4'h0;
              state_reg <= ST_ACK;
              if (state_reg == ST_ADDR) begin
                if (shift_reg[7:1] == `TARGET_ADDR) begin
                  o_sda_oe <= 1'b1;
                  byte_idx_reg <= 1'b0;
                  if (shift_reg[0]) begin
                    rd_word_reg <= rd_mux;
                    flag_clear_reg <= (cmd_reg == `CMD_INT_FLAG);
                    after_ack_reg <= ST_RDATA;
                  end else
                    after_ack_reg <= ST_CMD;
                end else
                  state_reg <= ST_SKIP;
              end else if (state_reg == ST_CMD) begin
                cmd_reg <= shift_reg;
                o_sda_oe <= 1'b1;
                after_ack_reg <= ST_WDATA;
              end else begin
                o_sda_oe <= 1'b1;
                byte_idx_reg <= !byte_idx_reg;
                after_ack_reg <= byte_idx_reg ? ST_SKIP : ST_WDATA;
                if (!byte_idx_reg)
                  low_byte_reg <= shift_reg;
                else begin
                  case (cmd_reg)
                    `CMD_CONF12: o_conf12 <= {shift_reg, low_byte_reg};
                    `CMD_CONF34: o_conf34 <= {shift_reg, low_byte_reg};
                    `CMD_CANCEL: o_cancel <= {shift_reg, low_byte_reg};
                    `CMD_THRESH_LO: thresh_lo_reg <= {shift_reg, low_byte_reg};
                    `CMD_THRESH_HI: thresh_hi_reg <= {shift_reg, low_byte_reg};
                    default: low_byte_reg <= low_byte_reg;
                  endcase
                end
              end
            end
          end
          ST_ACK: begin
            // release after the ninth clock, or start a read byte
            if (scl_fall) begin
              state_reg <= after_ack_reg;
              if (after_ack_reg == ST_RDATA) begin
                o_sda_oe <= !rd_word_reg[7];
                bit_cnt_reg <= 4'h1;
              end else
                o_sda_oe <= 1'b0;
            end
          end
          ST_RDATA: begin
            // open drain: enable pulls the line low for zero bits
            if (scl_fall) begin
              if (bit_cnt_reg == 4'h8) begin
                o_sda_oe <= 1'b0;
                state_reg <= ST_HACK;
              end else begin
                o_sda_oe <= !rd_word_reg[7 - bit_cnt_reg[2:0]];
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
              end
            end
          end
          ST_HACK: begin
            // host ack after low byte brings the high byte; nack ends
            if (scl_rise) begin
              if (sda_s || byte_idx_reg)
                state_reg <= ST_SKIP;
              else begin
                byte_idx_reg <= 1'b1;
                rd_word_reg <= {8'h00, rd_word_reg[15:8]};
                after_ack_reg <= ST_RDATA;
                state_reg <= ST_ACK;
              end
            end
          end
          ST_SKIP: o_sda_oe <= 1'b0;
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end

endmodule // prox_word_port

//--- prox_word_port_monitor.sv
// pin-level assertions for the proximity word port
`timescale 1ns/100ps
module prox_word_port_monitor (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_scl,
  input wire i_sda,
  input wire i_meas_valid,
  input wire [15:0] i_meas_count,
  input wire o_sda_out,
  input wire o_sda_oe,
  input wire o_int_n,
  input wire [15:0] o_conf12,
  input wire [15:0] o_conf34,
  input wire [15:0] o_cancel
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // device pulled the data line within the last two cycles
  sequence ack_recent;
    o_sda_oe || $past(o_sda_oe) || $past(o_sda_oe, 2);
  endsequence
  reset_vals_a: assert property ($rose(i_rst_n) |-> o_conf12 == 16'h0001 && o_cancel == 16'h0000 && o_int_n)
    else $error("bad reset value");
  open_drain_a: assert property (o_sda_out == 1'h0)
    else $error("data driven high");
  ack_hold_a: assert property (i_scl && o_sda_oe |=> o_sda_oe || !i_scl)
    else $error("data moved under high clock");
  ack_after_fall_a: assert property ($rose(o_sda_oe) |-> !$past(i_scl, 2))
    else $error("drive began without clock low");
  int_cause_a: assert property ($fell(o_int_n) |-> $past(i_meas_valid) && $past(o_conf12[1]))
    else $error("interrupt without enabled result");
  shut_ignore_a: assert property (o_conf12[0] && i_meas_valid |=> $stable(o_int_n))
    else $error("result taken in shutdown");
  int_clear_a: assert property ($rose(o_int_n) |-> ack_recent)
    else $error("interrupt cleared outside a read");
  conf_commit_a: assert property ($changed(o_conf12) || $changed(o_conf34) || $changed(o_cancel) |-> ack_recent)
    else $error("config changed outside an ack");
endmodule // prox_word_port_monitor

bind prox_word_port prox_word_port_monitor u_mon (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_scl(i_scl), .i_sda(i_sda),
  .i_meas_valid(i_meas_valid), .i_meas_count(i_meas_count), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
  .o_int_n(o_int_n), .o_conf12(o_conf12), .o_conf34(o_conf34), .o_cancel(o_cancel));

//--- i2c_host_model.sv
// bus host model making word writes and word reads
`timescale 1ns/100ps
module i2c_host_model (
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl = 1'h1,
  output logic o_sda_oe = 1'h0
);
  task tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // one bit: data set while clock low, line read just before clock falls
  task bit_x(input logic b, output logic r);
    o_sda_oe <= !b;
    tick(3);
    o_scl <= 1'h1;
    tick(4);
    r = i_sda;
    o_scl <= 1'h0;
    tick(1);
  endtask
  task xfer(input logic [8:0] d, output logic [7:0] v, output logic k);
    logic [8:0] q;
    for (int i = 8; i >= 0; i--) bit_x(d[i], q[i]);
    v = q[8:1];
    k = q[0];
  endtask
  // start when s is high, stop otherwise; clock stands high after a stop
  task cond(input logic s);
    o_sda_oe <= !s;
    tick(3);
    o_scl <= 1'h1;
    tick(4);
    o_sda_oe <= s;
    tick(4);
    if (s) begin
      o_scl <= 1'h0;
      tick(1);
    end
  endtask
  task write_word(input logic [6:0] a, input logic [7:0] c, input logic [15:0] w, output logic [3:0] n);
    logic [7:0] v;
    cond(1'h1);
    xfer({a, 2'h1}, v, n[3]);
    xfer({c, 1'h1}, v, n[2]);
    xfer({w[7:0], 1'h1}, v, n[1]);
    xfer({w[15:8], 1'h1}, v, n[0]);
    cond(1'h0);
  endtask
  task read_word(input logic [6:0] a, input logic [7:0] c, output logic [15:0] d, output logic [2:0] n);
    logic k;
    cond(1'h1);
    xfer({a, 2'h1}, d[7:0], n[2]);
    xfer({c, 1'h1}, d[7:0], n[1]);
    cond(1'h1);
    xfer({a, 2'h3}, d[7:0], n[0]);
    xfer(9'h1fe, d[7:0], k);
    xfer(9'h1ff, d[15:8], k);
    cond(1'h0);
  endtask
endmodule // i2c_host_model

//--- prox_word_port_bench.sv
// self-checking bench for the proximity word port
`timescale 1ns/100ps
module prox_word_port_bench;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic meas_valid = 1'h0;
  logic [15:0] meas_count = 16'h0000;
  logic [15:0] rd;
  logic [3:0] wn;
  logic [2:0] rn;
  wire scl, host_oe, sda_out, sda_oe, int_n;
  wire [15:0] conf12, conf34, cancel;
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  // open-drain data line with pull-up
  wire sda = !(host_oe || sda_oe);
  always #12.5 clk = !clk;
  prox_word_port u_dut (.i_clk(clk), .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda), .i_meas_valid(meas_valid),
    .i_meas_count(meas_count), .o_sda_out(sda_out), .o_sda_oe(sda_oe), .o_int_n(int_n), .o_conf12(conf12),
    .o_conf34(conf34), .o_cancel(cancel));
  i2c_host_model u_host (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(host_oe));
  task close_out;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      close_out;
    end
  end
  task pulse(input logic [15:0] c);
    meas_valid <= 1'h1;
    meas_count <= c;
    @(posedge clk);
    meas_valid <= 1'h0;
    repeat (2) @(posedge clk);
  endtask
  task wr(input logic [7:0] c, input logic [15:0] w);
    u_host.write_word(7'h41, c, w, wn);
    chk(16'h0000, {12'h000, wn});
  endtask
  task rdw(input logic [7:0] c);
    u_host.read_word(7'h41, c, rd, rn);
    chk(16'h0000, {13'h0000, rn});
  endtask
  task t_regs;
    chk(16'h0001, conf12);
    rdw(8'h00);
    chk(16'h0101, rd);
    rdw(8'h0e);
    chk(16'h4155, rd);
    chk(16'h0000, {15'h0000, sda_out});
    wr(8'h04, 16'ha55a);
    wr(8'h05, 16'h3cc3);
    wr(8'h08, 16'h1234);
    chk(16'ha55a, conf34);
    chk(16'h3cc3, cancel);
    rdw(8'h08);
    chk(16'h0000, rd);
    u_host.write_word(7'h42, 8'h04, 16'h0000, wn);
    chk(16'h000f, {12'h000, wn});
    chk(16'ha55a, conf34);
  endtask
  task t_meas;
    // leave shutdown first, or the first count is never taken
    wr(8'h03, 16'h0000);
    chk(16'h0000, conf12);
    pulse(16'h1234);
    rdw(8'h08);
    chk(16'h0fff, rd);
    wr(8'h03, 16'h0801);
    pulse(16'h5555);
    rdw(8'h08);
    chk(16'h0fff, rd);
    wr(8'h03, 16'h0800);
    pulse(16'hfedc);
    // new result lands while the low byte is on the wire
    fork
      rdw(8'h09);
      begin
        repeat (300) @(posedge clk);
        pulse(16'h0102);
      end
    join
    chk(16'hfedc, rd);
    rdw(8'h0a);
    chk(16'h0102, rd);
  endtask
  task t_int;
    wr(8'h06, 16'h0010);
    wr(8'h07, 16'h0100);
    rdw(8'h06);
    chk(16'h0010, rd);
    wr(8'h03, 16'h0002);
    chk(16'h0002, conf12);
    for (int i = 0; i < 2; i++) begin
      pulse(i ? 16'h0005 : 16'h0200);
      chk(16'h0000, {15'h0000, int_n});
      rdw(8'h0d);
      chk(i ? 16'h0100 : 16'h0200, rd & 16'h0300);
      chk(16'h0001, {15'h0000, int_n});
    end
    // shutdown with interrupts enabled must not raise the interrupt
    wr(8'h03, 16'h0003);
    pulse(16'h0200);
    chk(16'h0001, {15'h0000, int_n});
  endtask
  // reset in mid-run with an interrupt pending and registers written
  task t_reset;
    wr(8'h03, 16'h0002);
    pulse(16'h0200);
    chk(16'h0000, {15'h0000, int_n});
    rst_n <= 1'h0;
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    repeat (4) @(posedge clk);
    chk(16'h0001, conf12);
    chk(16'h0000, conf34);
    chk(16'h0000, cancel);
    chk(16'h0001, {15'h0000, int_n});
    rdw(8'h0d);
    chk(16'h0000, rd & 16'h0300);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    repeat (4) @(posedge clk);
    t_regs;
    t_meas;
    t_int;
    t_reset;
    close_out;
  end
endmodule // prox_word_port_bench
